// ---- hw/cfg_pkg.sv ----
// Shared constants, scheme codes and helpers of the configuration handshake.
// Operation
// - Scheme chosen from static scheme select straps.
// - Reconfig low: drop configuration, reset, float I/O.
// - Reconfig high again starts a new configuration.
// - Status held low after power-up, released later.
// - Configuration error pulls status line low.
// - External status low during configuration forces error.
// - Status line changes ignored in user mode.
// - Host pulls reconfig low to get reconfiguration.
// - Done line held low before and during configuration.
// - Done released after error-free data, init begins.
// - Done line high lets device enter user mode.
// - Done line low ignored after initialization.
// - Configuration accepted only while chip enable low.
// - Host keeps chip enable low at all times.
// - First device enable tied low; chain output feeds next.
// - Chain enable output driven low when configured.
// - Chain option off: pin is user I/O.
// - Chip select enables memory in active modes.
package cfg_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 100;
	localparam int POR_TIME_NS      = 100000;
	localparam int POR_CYCLES       = (POR_TIME_NS + CLK_PERIOD_NS - 1) /
	                                  CLK_PERIOD_NS;
	localparam int RECFG_LOW_NS     = 2000;
	localparam int RECFG_LOW_CYCLES = (RECFG_LOW_NS + CLK_PERIOD_NS - 1) /
	                                  CLK_PERIOD_NS;
	localparam int WORD_GAP_CYCLES  = 4;
	localparam int SETTLE_CYCLES    = 3;
	localparam int CNT_W            = 16;
	localparam int CFG_WORDS_DEF    = 16;

	// ------------------------------------------------------------------
	// Scheme select encoding
	// ------------------------------------------------------------------
	localparam int              SCHEME_W               = 3;
	localparam logic [2:0]      SCHEME_ACTIVE_SERIAL   = 3'h2;
	localparam logic [2:0]      SCHEME_ACTIVE_PARALLEL = 3'h3;

	function automatic logic scheme_is_active(input logic [SCHEME_W-1:0] s);
		return (s == SCHEME_ACTIVE_SERIAL) || (s == SCHEME_ACTIVE_PARALLEL);
	endfunction : scheme_is_active

	function automatic logic [CNT_W-1:0] cnt_last(input int cycles);
		return CNT_W'(cycles - 1);
	endfunction : cnt_last

endpackage : cfg_pkg

// ---- hw/cfg_link_if.sv ----
// Pin-level link between the configured device and its configuration host.
`timescale 1ns/10ps
`default_nettype none
interface cfg_link_if
	import cfg_pkg::*;
;
	logic                reconfig_n;
	logic                chip_enable_n;
	logic                data_toggle;
	logic [SCHEME_W-1:0] scheme_select;
	logic                status_dev_oe;
	logic                status_host_oe;
	logic                done_dev_oe;
	logic                done_host_oe;
	logic                chain_oe;
	logic                chip_select_n;
	logic                status_line;
	logic                done_line;
	logic                chain_enable_out_n;

	// Pulled-up open-drain wires: low when any party pulls.
	assign status_line        = ~(status_dev_oe | status_host_oe);
	assign done_line          = ~(done_dev_oe | done_host_oe);
	assign chain_enable_out_n = ~chain_oe;

	modport dev (
		input  reconfig_n, chip_enable_n, data_toggle, scheme_select,
		input  status_line, done_line,
		output status_dev_oe, done_dev_oe, chain_oe, chip_select_n
	);

	modport host (
		output reconfig_n, chip_enable_n, data_toggle, scheme_select,
		output status_host_oe, done_host_oe,
		input  status_line, done_line, chain_enable_out_n, chip_select_n
	);
endinterface : cfg_link_if
`default_nettype wire

// ---- hw/cfg_sync.sv ----
// Two-flop synchroniser for a group of independent level inputs.
`timescale 1ns/10ps
`default_nettype none
module cfg_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,  // system clock
	input  wire logic         rst,  // async reset, active high
	input  wire logic [W-1:0] d,    // asynchronous levels
	output logic      [W-1:0] q     // synchronised levels
);
	logic [W-1:0] meta_q;

	// Reset value is all ones: the reconfig, status, done and toggle lines idle high.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q <= '1;
			q      <= '1;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : cfg_sync
`default_nettype wire

// ---- hw/cfg_device.sv ----
// Configured-device end: power-on, reconfiguration, status and done control.
`timescale 1ns/10ps
`default_nettype none
module cfg_device
	import cfg_pkg::*;
#(
	parameter int CFG_WORDS = CFG_WORDS_DEF
) (
	input  wire logic clk,                   // system clock, 10 MHz
	input  wire logic rst,                   // async reset, active high
	cfg_link_if.dev   link,                  // pins toward the host
	input  wire logic cfg_error,             // internal data check failed
	input  wire logic chain_opt_on,          // chain enable option on
	input  wire logic user_chain_oe,         // user drive of chain pin
	output logic      user_io_hiz,           // all user I/O floating
	output logic      in_user_mode,          // device is in user mode
	output logic      cfg_error_flag,        // error state reached
	output logic      active_serial_mode,    // latched scheme: serial
	output logic      active_parallel_mode   // latched scheme: parallel
);

	// ------------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------------
	if (CFG_WORDS < 1 || CFG_WORDS >= (1 << CNT_W)) begin : g_bad_words
		$error("CFG_WORDS out of range");
	end

	// ------------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------------
	localparam int SW = 5 + SCHEME_W;

	logic [SW-1:0]       sync_q;
	logic                reconfig_n_s;
	logic                chip_enable_n_s;
	logic                status_s;
	logic                done_s;
	logic                toggle_s;
	logic [SCHEME_W-1:0] scheme_s;

	cfg_sync #(.W(SW)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({link.reconfig_n, link.chip_enable_n, link.status_line,
		       link.done_line, link.data_toggle, link.scheme_select}),
		.q   (sync_q)
	);

	assign {reconfig_n_s, chip_enable_n_s, status_s, done_s, toggle_s,
	        scheme_s} = sync_q;

	// ------------------------------------------------------------------
	// State machine
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_POR,
		ST_RESET,
		ST_CONFIG,
		ST_INIT,
		ST_USER,
		ST_ERROR
	} dev_state_t;

	dev_state_t          state_q;
	dev_state_t          state_d;
	logic [CNT_W-1:0]    cnt_q;
	logic [CNT_W-1:0]    words_q;
	logic                toggle_prev_q;
	logic                word_taken;
	logic                settled;
	logic                ext_status_low;
	logic [SCHEME_W-1:0] scheme_q;

	// A word arrives on each change of the data toggle, but only while
	// the chip enable input is low.
	assign word_taken = (toggle_s != toggle_prev_q) && !chip_enable_n_s;

	// The status line needs a few cycles after our own release before a low
	// there can be blamed on someone else.
	assign settled        = cnt_q >= CNT_W'(SETTLE_CYCLES);
	assign ext_status_low = settled && !status_s;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_POR: begin
				if (cnt_q == cnt_last(POR_CYCLES))
					state_d = reconfig_n_s ? ST_CONFIG : ST_RESET;
			end
			ST_RESET: begin
				if (reconfig_n_s)
					state_d = ST_CONFIG;
			end
			ST_CONFIG: begin
				if (!reconfig_n_s)
					state_d = ST_RESET;
				else if (cfg_error || ext_status_low)
					state_d = ST_ERROR;
				else if (word_taken && words_q == CNT_W'(CFG_WORDS - 1))
					state_d = ST_INIT;
			end
			ST_INIT: begin
				if (!reconfig_n_s)
					state_d = ST_RESET;
				else if (ext_status_low)
					state_d = ST_ERROR;
				else if (done_s)
					state_d = ST_USER;
			end
			ST_USER: begin
				// Status and done lines are not looked at here.
				if (!reconfig_n_s)
					state_d = ST_RESET;
			end
			ST_ERROR: begin
				if (!reconfig_n_s)
					state_d = ST_RESET;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state_q <= ST_POR;
		else
			state_q <= state_d;
	end

	// Cycle counter restarts on every state change.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cnt_q <= '0;
		else if (state_d != state_q)
			cnt_q <= '0;
		else if (cnt_q != '1)
			cnt_q <= cnt_q + CNT_W'(1);
	end

	// ------------------------------------------------------------------
	// Data word counting
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			words_q <= '0;
		else if (state_q != ST_CONFIG)
			words_q <= '0;
		else if (word_taken)
			words_q <= words_q + CNT_W'(1);
	end

	// The toggle is tracked on every cycle, so a change made while the chip
	// enable is high, or outside configuration, never counts later as a word.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			toggle_prev_q <= 1'b1;
		else
			toggle_prev_q <= toggle_s;
	end

	// ------------------------------------------------------------------
	// Scheme capture
	// ------------------------------------------------------------------
	// The straps are static, so they are caught once per configuration as
	// the device leaves reset rather than followed continuously.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			scheme_q <= '0;
		else if (state_d == ST_CONFIG && state_q != ST_CONFIG)
			scheme_q <= scheme_s;
	end

	// ------------------------------------------------------------------
	// Pin drives: open-drain status and done, plain chain and chip select
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			link.status_dev_oe <= 1'b1;
		else
			link.status_dev_oe <= state_q == ST_POR || state_q == ST_RESET ||
			                      state_q == ST_ERROR;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			link.done_dev_oe <= 1'b1;
		else
			link.done_dev_oe <= state_q != ST_INIT &&
			                    state_q != ST_USER;
	end

	// The chain output stays released until this device is configured,
	// which keeps the next device in the chain disabled.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			link.chain_oe <= 1'b0;
		else if (state_q != ST_USER)
			link.chain_oe <= 1'b0;
		else if (chain_opt_on)
			link.chain_oe <= 1'b1;
		else
			link.chain_oe <= user_chain_oe;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			link.chip_select_n <= 1'b1;
		else
			link.chip_select_n <= !(state_q == ST_CONFIG &&
			                        scheme_is_active(scheme_q));
	end

	// ------------------------------------------------------------------
	// User-side outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			user_io_hiz    <= 1'b1;
			in_user_mode   <= 1'b0;
			cfg_error_flag <= 1'b0;
		end else begin
			user_io_hiz    <= state_q != ST_USER;
			in_user_mode   <= state_q == ST_USER;
			cfg_error_flag <= state_q == ST_ERROR;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			active_serial_mode   <= 1'b0;
			active_parallel_mode <= 1'b0;
		end else begin
			active_serial_mode   <= scheme_q == SCHEME_ACTIVE_SERIAL;
			active_parallel_mode <= scheme_q == SCHEME_ACTIVE_PARALLEL;
		end
	end

endmodule : cfg_device
`default_nettype wire

// ---- hw/cfg_host.sv ----
// Host end: pulses reconfiguration, feeds data words and watches status.
`timescale 1ns/10ps
`default_nettype none
module cfg_host
	import cfg_pkg::*;
#(
	parameter int CFG_WORDS = CFG_WORDS_DEF
) (
	input  wire logic                clk,        // system clock, 10 MHz
	input  wire logic                rst,        // async reset, active high
	cfg_link_if.host                 link,       // pins toward the device
	input  wire logic                start,      // one-cycle: configure
	input  wire logic                abort,      // one-cycle: report failure
	input  wire logic                hold_init,  // level: hold done low
	input  wire logic [SCHEME_W-1:0] scheme,     // board strap level
	output logic                     busy,       // sequence running
	output logic                     cfg_done,   // device configured
	output logic                     cfg_fail    // failure seen or sent
);
	if (CFG_WORDS < 1 || CFG_WORDS >= (1 << CNT_W)) begin : g_bad_words
		$error("CFG_WORDS out of range");
	end

	// ------------------------------------------------------------------
	// Synchronisation and state
	// ------------------------------------------------------------------
	logic status_s;
	logic done_s;

	cfg_sync #(.W(2)) u_sync (
		.clk (clk),
		.rst (rst),
		.d   ({link.status_line, link.done_line}),
		.q   ({status_s, done_s})
	);

	typedef enum logic [2:0] {
		H_IDLE,
		H_PULSE,
		H_WAIT_STATUS,
		H_SEND,
		H_WAIT_DONE,
		H_FAIL
	} host_state_t;

	host_state_t      state_q;
	host_state_t      state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] words_q;
	logic             send_now;

	assign send_now = state_q == H_SEND &&
	                  cnt_q == cnt_last(WORD_GAP_CYCLES);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			H_IDLE, H_FAIL: begin
				if (start)
					state_d = H_PULSE;
			end
			H_PULSE: begin
				if (cnt_q == cnt_last(RECFG_LOW_CYCLES))
					state_d = H_WAIT_STATUS;
			end
			H_WAIT_STATUS: begin
				if (status_s)
					state_d = H_SEND;
			end
			H_SEND: begin
				if (!status_s)
					state_d = H_FAIL;
				else if (send_now && words_q == CNT_W'(CFG_WORDS - 1))
					state_d = H_WAIT_DONE;
			end
			H_WAIT_DONE: begin
				if (!status_s)
					state_d = H_FAIL;
				else if (done_s)
					state_d = H_IDLE;
			end
		endcase
		if (abort && state_q != H_IDLE && state_q != H_FAIL)
			state_d = H_FAIL;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			state_q <= H_IDLE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cnt_q <= '0;
		else if (state_d != state_q || send_now)
			cnt_q <= '0;
		else if (cnt_q != '1)
			cnt_q <= cnt_q + CNT_W'(1);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			words_q <= '0;
		else if (state_q != H_SEND)
			words_q <= '0;
		else if (send_now)
			words_q <= words_q + CNT_W'(1);
	end

	// ------------------------------------------------------------------
	// Pin drives
	// ------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link.reconfig_n     <= 1'b1;
			link.chip_enable_n  <= 1'b0;
			link.data_toggle    <= 1'b1;
			link.scheme_select  <= '0;
			link.status_host_oe <= 1'b0;
			link.done_host_oe   <= 1'b0;
		end else begin
			// Status alone never reconfigures; the reconfig pulse does.
			link.reconfig_n     <= state_q != H_PULSE;
			link.chip_enable_n  <= 1'b0;
			link.scheme_select  <= scheme;
			link.status_host_oe <= state_q == H_FAIL;
			link.done_host_oe   <= hold_init;
			if (send_now)
				link.data_toggle <= ~link.data_toggle;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy     <= 1'b0;
			cfg_done <= 1'b0;
			cfg_fail <= 1'b0;
		end else begin
			busy     <= state_q != H_IDLE && state_q != H_FAIL;
			cfg_done <= (state_q == H_WAIT_DONE && state_d == H_IDLE) ||
			            (cfg_done && !start);
			cfg_fail <= state_q == H_FAIL;
		end
	end

endmodule : cfg_host
`default_nettype wire

// ---- tb/cfg_link_asserts.sv ----
// Concurrent checks on the link between the device and host ends.
`timescale 1ns/10ps
`default_nettype none
module cfg_link_asserts (
	input wire logic clk,                // system clock
	input wire logic rst,                // async reset, active high
	input wire logic reconfig_n,         // reconfiguration request
	input wire logic status_dev_oe,      // device pulls status low
	input wire logic status_host_oe,     // host pulls status low
	input wire logic done_dev_oe,        // device pulls done low
	input wire logic done_host_oe,       // host pulls done low
	input wire logic chain_oe,           // device pulls chain pin low
	input wire logic chip_select_n,      // memory chip select
	input wire logic status_line,        // wired status level
	input wire logic done_line,          // wired done level
	input wire logic chain_enable_out_n  // chain pin level
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------------
	// Request steps
	// ------------------------------------------------------------------
	sequence s_req_held;
		!reconfig_n [*6];
	endsequence
	sequence s_req_end;
		$rose(reconfig_n);
	endsequence

	a_status_wired_and: assert property (
		status_line == !(status_dev_oe || status_host_oe))
		else $error("status line level wrong");
	a_done_wired_and: assert property (
		done_line == !(done_dev_oe || done_host_oe))
		else $error("done line level wrong");
	a_chain_pin_level: assert property (
		chain_enable_out_n == !chain_oe)
		else $error("chain pin level wrong");
	a_por_holds_status: assert property (
		$fell(rst) |-> status_dev_oe [*8])
		else $error("status released too early after power-up");
	a_reset_pulls_low: assert property (
		s_req_held |-> status_dev_oe && done_dev_oe)
		else $error("request low did not reset device");
	a_done_held_early: assert property (
		s_req_end |-> done_dev_oe [*8])
		else $error("done released before data arrived");
	a_chipsel_in_config: assert property (
		!chip_select_n |-> done_dev_oe)
		else $error("chip select active outside configuration");
	a_chain_after_done: assert property (
		chain_oe |-> !done_dev_oe)
		else $error("chain pin low before configuration done");
	a_error_is_sticky: assert property (
		$rose(status_dev_oe) && reconfig_n |=> status_dev_oe [*8])
		else $error("error report not held");
endmodule : cfg_link_asserts
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench joining the device and host ends over the link.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import cfg_pkg::*;
	localparam int WORDS = 4;
	logic       clk, rst, cfg_error, chain_opt_on, user_chain_oe;
	logic       start, abort, hold_init, busy, cfg_done, cfg_fail;
	logic       user_io_hiz, in_user_mode, cfg_error_flag, b_user;
	logic       active_serial_mode, active_parallel_mode;
	logic [2:0] scheme;
	int         err_count, n_compared;

	cfg_link_if link ();
	cfg_link_if link_b ();
	cfg_device #(.CFG_WORDS(WORDS)) i_cfg_device (.clk(clk), .rst(rst),
		.link(link), .cfg_error(cfg_error), .chain_opt_on(chain_opt_on),
		.user_chain_oe(user_chain_oe), .user_io_hiz(user_io_hiz),
		.in_user_mode(in_user_mode), .cfg_error_flag(cfg_error_flag),
		.active_serial_mode(active_serial_mode),
		.active_parallel_mode(active_parallel_mode));
	cfg_host #(.CFG_WORDS(WORDS)) i_cfg_host (.clk(clk), .rst(rst),
		.link(link), .start(start), .abort(abort), .hold_init(hold_init),
		.scheme(scheme), .busy(busy), .cfg_done(cfg_done),
		.cfg_fail(cfg_fail));
	// Second device is driven by the bench to break host-side rules.
	cfg_device #(.CFG_WORDS(WORDS)) i_cfg_device_b (.clk(clk), .rst(rst),
		.link(link_b), .cfg_error(1'b0), .chain_opt_on(1'b1),
		.user_chain_oe(1'b0), .user_io_hiz(), .in_user_mode(b_user),
		.cfg_error_flag(), .active_serial_mode(),
		.active_parallel_mode());
	cfg_link_asserts i_cfg_link_asserts (.clk(clk), .rst(rst),
		.reconfig_n(link.reconfig_n), .status_dev_oe(link.status_dev_oe),
		.status_host_oe(link.status_host_oe),
		.done_dev_oe(link.done_dev_oe), .done_host_oe(link.done_host_oe),
		.chain_oe(link.chain_oe), .chip_select_n(link.chip_select_n),
		.status_line(link.status_line), .done_line(link.done_line),
		.chain_enable_out_n(link.chain_enable_out_n));

	// ------------------------------------------------------------------
	// Common tasks
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic seen,
		input logic exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %b seen %b", what, exp, seen);
		end
	endtask : check

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	task automatic pulse_start;
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (3) @(negedge clk);
	endtask : pulse_start

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_power_up;
		int i;
		@(negedge clk);
		check("por_status", link.status_line, 1'b0);
		check("por_done", link.done_line, 1'b0);
		for (i = 0; i < 1100 && link.status_line !== 1'b1; i++)
			@(negedge clk);
		check("por_length", i >= POR_CYCLES - 2 &&
			i <= POR_CYCLES + 2, 1'b1);
		check("por_released", link.status_line, 1'b1);
	endtask : t_power_up

	task automatic t_config(input logic [2:0] s, input logic chain_on);
		int   i;
		logic cs_seen;
		logic hiz_seen;
		cs_seen = 1'b0;
		hiz_seen = 1'b0;
		@(posedge clk);
		scheme <= s;
		chain_opt_on <= chain_on;
		pulse_start();
		for (i = 0; i < 400 && cfg_done !== 1'b1; i++) begin
			@(negedge clk);
			if (link.chip_select_n === 1'b0) cs_seen = 1'b1;
			if (user_io_hiz === 1'b1) hiz_seen = 1'b1;
		end
		repeat (6) @(negedge clk);
		check("chip_select", cs_seen, s == SCHEME_ACTIVE_SERIAL ||
			s == SCHEME_ACTIVE_PARALLEL);
		check("io_float", hiz_seen, 1'b1);
		check("user_mode", in_user_mode, 1'b1);
		check("io_driven", user_io_hiz, 1'b0);
		check("host_done", cfg_done, 1'b1);
		check("host_idle", busy, 1'b0);
		check("host_ok", cfg_fail, 1'b0);
		check("serial", active_serial_mode,
			s == SCHEME_ACTIVE_SERIAL);
		check("parallel", active_parallel_mode,
			s == SCHEME_ACTIVE_PARALLEL);
		check("chain_pin", link.chain_enable_out_n, !chain_on);
		@(posedge clk);
		user_chain_oe <= 1'b1;
		repeat (5) @(negedge clk);
		check("chain_user", link.chain_enable_out_n, 1'b0);
		@(posedge clk);
		user_chain_oe <= 1'b0;
	endtask : t_config

	task automatic t_fail(input logic by_host);
		int i;
		pulse_start();
		for (i = 0; i < 60 && link.status_line !== 1'b0; i++)
			@(negedge clk);
		for (i = 0; i < 60 && link.status_line !== 1'b1; i++)
			@(negedge clk);
		repeat (6) @(posedge clk);
		if (by_host) abort <= 1'b1;
		else cfg_error <= 1'b1;
		@(posedge clk);
		abort <= 1'b0;
		cfg_error <= 1'b0;
		for (i = 0; i < 20 && cfg_error_flag !== 1'b1; i++)
			@(negedge clk);
		repeat (30) @(negedge clk);
		check("err_flag", cfg_error_flag, 1'b1);
		check("err_status", link.status_line, 1'b0);
		check("err_done", link.done_line, 1'b0);
		check("err_user", in_user_mode, 1'b0);
		@(posedge clk);
		abort <= 1'b1;
		@(posedge clk);
		abort <= 1'b0;
		repeat (2) @(negedge clk);
		check("host_fail", cfg_fail, 1'b1);
	endtask : t_fail

	task automatic t_hold_done;
		int i;
		@(posedge clk);
		hold_init <= 1'b1;
		pulse_start();
		for (i = 0; i < 400 && link.done_dev_oe !== 1'b0; i++)
			@(negedge clk);
		repeat (10) @(negedge clk);
		check("held_done", link.done_line, 1'b0);
		check("held_user", in_user_mode, 1'b0);
		check("held_busy", busy, 1'b1);
		@(posedge clk);
		hold_init <= 1'b0;
		repeat (8) @(negedge clk);
		check("freed_user", in_user_mode, 1'b1);
	endtask : t_hold_done

	task automatic b_config(input logic ce_n);
		int i;
		@(posedge clk);
		link_b.chip_enable_n <= ce_n;
		link_b.reconfig_n <= 1'b0;
		repeat (RECFG_LOW_CYCLES) @(posedge clk);
		link_b.reconfig_n <= 1'b1;
		for (i = 0; i < 100 && link_b.status_line !== 1'b1; i++)
			@(negedge clk);
		repeat (WORDS) begin
			repeat (WORD_GAP_CYCLES) @(posedge clk);
			link_b.data_toggle <= ~link_b.data_toggle;
		end
		repeat (12) @(negedge clk);
	endtask : b_config

	task automatic t_far_faults;
		b_config(1'b0);
		check("b_user", b_user, 1'b1);
		@(posedge clk);
		link_b.status_host_oe <= 1'b1;
		repeat (12) @(negedge clk);
		check("status_ignored", b_user, 1'b1);
		@(posedge clk);
		link_b.status_host_oe <= 1'b0;
		link_b.done_host_oe <= 1'b1;
		repeat (12) @(negedge clk);
		check("done_ignored", b_user, 1'b1);
		@(posedge clk);
		link_b.done_host_oe <= 1'b0;
		b_config(1'b1);
		check("ce_off_done", link_b.done_line, 1'b0);
		check("ce_off_user", b_user, 1'b0);
		// A word sent while disabled must not count once enable returns.
		@(posedge clk);
		link_b.data_toggle <= ~link_b.data_toggle;
		repeat (WORD_GAP_CYCLES) @(posedge clk);
		link_b.chip_enable_n <= 1'b0;
		repeat (WORDS - 1) begin
			repeat (WORD_GAP_CYCLES) @(posedge clk);
			link_b.data_toggle <= ~link_b.data_toggle;
		end
		repeat (12) @(negedge clk);
		check("ce_off_stale", b_user, 1'b0);
		check("ce_off_held", link_b.done_line, 1'b0);
	endtask : t_far_faults

	// ------------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Whole run is about 1600 cycles; the limit leaves ample slack.
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		stop_test();
	end

	initial begin
		{cfg_error, chain_opt_on, user_chain_oe} = 3'h0;
		{start, abort, hold_init, scheme} = 6'h00;
		{link_b.status_host_oe, link_b.done_host_oe} = 2'h0;
		{link_b.reconfig_n, link_b.chip_enable_n} = 2'h2;
		{link_b.data_toggle, link_b.scheme_select} = 4'h8;
		err_count = 0;
		n_compared = 0;
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_power_up();
		t_config(SCHEME_ACTIVE_SERIAL, 1'b1);
		t_config(SCHEME_ACTIVE_PARALLEL, 1'b0);
		t_fail(1'b1);
		t_config(3'h0, 1'b1);
		t_fail(1'b0);
		t_hold_done();
		t_far_faults();
		stop_test();
	end
endmodule : testbench
`default_nettype wire
